// ==== rtl/pipe_ctrl_pkg.sv ====
// Constants shared by the five-stage instruction sequencer.
// Assumes a 32-bit instruction word and a 512-long local memory.
package pipe_ctrl_pkg;

	// ==========================================================
	// Widths
	localparam int unsigned WORD_W = 32;
	localparam int unsigned ADDR_W = 9;

	// ==========================================================
	// Instruction word fields
	localparam int unsigned OPC_MSB = 31;
	localparam int unsigned OPC_LSB = 26;
	localparam int unsigned WRITE_BIT = 23;
	localparam int unsigned IMM_BIT = 22;
	localparam int unsigned DST_MSB = 17;
	localparam int unsigned DST_LSB = 9;
	localparam int unsigned SRC_MSB = 8;
	localparam int unsigned SRC_LSB = 0;

	// ==========================================================
	// Opcode classes
	localparam logic [5:0] OPC_JUMP = 6'h17;
	localparam logic [5:0] OPC_DECREMENT_JUMP_NONZERO = 6'h39;
	localparam logic [5:0] OPC_TEST_JUMP_NONZERO = 6'h3A;
	localparam logic [5:0] OPC_TEST_JUMP_ZERO = 6'h3B;
	localparam logic [5:0] OPC_DECREMENT_JUMP_ZERO = 6'h38;
	localparam logic [2:0] HUB_CLASS = 3'h0;
	localparam int unsigned HUB_CLASS_LSB = 3;

	// ==========================================================
	// Slot timing
	localparam int unsigned SLOT_CYCLES = 4;
	localparam int unsigned LIFE_CYCLES = 6;
	localparam int unsigned HUB_MIN_CYCLES = 8;
	localparam int unsigned HUB_MAX_CYCLES = 23;
	localparam logic [1:0] PH_FETCH = 2'h0;
	localparam logic [1:0] PH_WRITE = 2'h1;
	localparam logic [1:0] PH_SOURCE = 2'h2;
	localparam logic [1:0] PH_DEST = 2'h3;

	// ==========================================================
	// Reset value and step
	localparam logic [ADDR_W-1:0] PC_RESET = 9'h000;
	localparam logic [ADDR_W-1:0] PC_STEP = 9'h001;

endpackage

// ==== rtl/five_stage_instruction_pipeline.sv ====
// Sequencer for one core: fetch, source, destination, execute, writeback.
// Assumes a single-port local memory with combinational read data, an
// external ALU answering within one cycle, and a hub grant on the same clock.
//
// What this block does
// - Each instruction lives six cycles; overlap yields one per four cycles.
// - Fetch instruction N at the program counter in slot cycle one.
// - Next cycle writes back the previous instruction's result, after the fetch.
// - Immediate flag set: the 9-bit source field is the source value.
// - Immediate flag clear: read the source location in slot cycle three.
// - Read the destination location in slot cycle four.
// - ALU gets one full cycle; executing instruction touches no memory then.
// - During the ALU cycle, fetch the next instruction.
// - Slot cycle six writes the result back, finishing stage five.
// - Rewriting the very next instruction runs its old copy.
// - Conditional jumps resolve at end of ALU cycle; prefetch the taken path.
// - Untaken conditional jump discards the prefetch, costing one idle slot.
// - Unconditional jumps, calls and returns always take four cycles.
// - Hub instructions hold execute until grant: eight to twenty-three cycles.
module five_stage_instruction_pipeline #(
	parameter logic [pipe_ctrl_pkg::ADDR_W-1:0] START_ADDR = pipe_ctrl_pkg::PC_RESET
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	output logic [pipe_ctrl_pkg::ADDR_W-1:0] mem_addr,
	output logic mem_rd,
	output logic mem_we,
	output logic [pipe_ctrl_pkg::WORD_W-1:0] mem_wdata,
	input wire logic [pipe_ctrl_pkg::WORD_W-1:0] mem_rdata,
	output logic alu_go,
	output logic [pipe_ctrl_pkg::WORD_W-1:0] alu_ins,
	output logic [pipe_ctrl_pkg::WORD_W-1:0] alu_src,
	output logic [pipe_ctrl_pkg::WORD_W-1:0] alu_dst,
	output logic [pipe_ctrl_pkg::ADDR_W-1:0] alu_ret_addr,
	input wire logic [pipe_ctrl_pkg::WORD_W-1:0] alu_result,
	input wire logic alu_write,
	input wire logic alu_take,
	output logic hub_req,
	input wire logic hub_grant,
	output logic retire,
	output logic bubble,
	output logic [pipe_ctrl_pkg::ADDR_W-1:0] pc,
	output logic [1:0] phase
);

	localparam int unsigned AW = pipe_ctrl_pkg::ADDR_W;
	localparam int unsigned DW = pipe_ctrl_pkg::WORD_W;

	// ==========================================================
	// Decode helpers
	function automatic logic [5:0] opc_of(input logic [DW-1:0] ins);
		opc_of = ins[pipe_ctrl_pkg::OPC_MSB:pipe_ctrl_pkg::OPC_LSB];
	endfunction

	function automatic logic is_uncond_jump(input logic [DW-1:0] ins);
		is_uncond_jump = (opc_of(ins) == pipe_ctrl_pkg::OPC_JUMP);
	endfunction

	function automatic logic is_cond_jump(input logic [DW-1:0] ins);
		logic [5:0] o;
		o = opc_of(ins);
		is_cond_jump = (o == pipe_ctrl_pkg::OPC_DECREMENT_JUMP_NONZERO)
			|| (o == pipe_ctrl_pkg::OPC_DECREMENT_JUMP_ZERO)
			|| (o == pipe_ctrl_pkg::OPC_TEST_JUMP_NONZERO)
			|| (o == pipe_ctrl_pkg::OPC_TEST_JUMP_ZERO);
	endfunction

	function automatic logic is_hub(input logic [DW-1:0] ins);
		logic [5:0] o;
		o = opc_of(ins);
		is_hub = (o[5:pipe_ctrl_pkg::HUB_CLASS_LSB] == pipe_ctrl_pkg::HUB_CLASS);
	endfunction

	function automatic logic [AW-1:0] src_field(input logic [DW-1:0] ins);
		src_field = ins[pipe_ctrl_pkg::SRC_MSB:pipe_ctrl_pkg::SRC_LSB];
	endfunction

	function automatic logic [AW-1:0] dst_field(input logic [DW-1:0] ins);
		dst_field = ins[pipe_ctrl_pkg::DST_MSB:pipe_ctrl_pkg::DST_LSB];
	endfunction

	function automatic logic imm_of(input logic [DW-1:0] ins);
		imm_of = ins[pipe_ctrl_pkg::IMM_BIT];
	endfunction

	function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
		next_addr = a + pipe_ctrl_pkg::PC_STEP;
	endfunction

	// ==========================================================
	// State
	logic [1:0] phase_r;
	logic [AW-1:0] pc_r;
	logic [DW-1:0] ir_r;
	logic ir_valid_r;
	logic [AW-1:0] ir_pc_r;
	logic [DW-1:0] src_r;
	logic [DW-1:0] dst_r;
	logic [DW-1:0] ex_ir_r;
	logic ex_valid_r;
	logic [AW-1:0] ex_pc_r;
	logic [DW-1:0] ex_src_r;
	logic [AW-1:0] ex_ret_r;
	logic [DW-1:0] res_r;
	logic [AW-1:0] res_addr_r;
	logic res_we_r;
	logic bubble_r;

	// ==========================================================
	// Slot control
	logic ex_jump;
	logic ex_cond;
	logic stall;
	logic slot_end;
	logic fetch_cyc;
	logic [AW-1:0] fetch_addr;
	logic untaken;

	assign ex_jump = ex_valid_r && is_uncond_jump(ex_ir_r);
	assign ex_cond = ex_valid_r && is_cond_jump(ex_ir_r);
	assign stall = (phase_r == pipe_ctrl_pkg::PH_FETCH) && ex_valid_r
		&& is_hub(ex_ir_r) && !hub_grant;
	assign fetch_cyc = run && (phase_r == pipe_ctrl_pkg::PH_FETCH);
	assign slot_end = run && (phase_r == pipe_ctrl_pkg::PH_DEST);
	assign untaken = fetch_cyc && !stall && ex_cond && !alu_take;

	// Taken path is always prefetched
	always_comb begin
		fetch_addr = pc_r;
		if (ex_jump || ex_cond) begin
			fetch_addr = src_field(ex_src_r);
		end
	end

	// Phase counter, held in execute while the hub is busy
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= pipe_ctrl_pkg::PH_FETCH;
		end else if (run && !stall) begin
			phase_r <= phase_r + 2'h1;
		end
	end

	// ==========================================================
	// Program counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_r <= START_ADDR;
		end else if (untaken) begin
			pc_r <= next_addr(ex_pc_r);
		end else if (fetch_cyc && !stall) begin
			pc_r <= next_addr(fetch_addr);
		end
	end

	// ==========================================================
	// Fetch stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ir_r <= '0;
			ir_valid_r <= 1'b0;
			ir_pc_r <= pipe_ctrl_pkg::PC_RESET;
		end else if (fetch_cyc && !stall) begin
			ir_r <= mem_rdata;
			ir_valid_r <= !untaken;
			ir_pc_r <= fetch_addr;
		end
	end

	// ==========================================================
	// Operand stages
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src_r <= '0;
		end else if (run && phase_r == pipe_ctrl_pkg::PH_WRITE
			&& imm_of(ir_r)) begin
			src_r <= {{(DW - AW){1'b0}}, src_field(ir_r)};
		end else if (run && phase_r == pipe_ctrl_pkg::PH_SOURCE
			&& !imm_of(ir_r)) begin
			src_r <= mem_rdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dst_r <= '0;
		end else if (run && phase_r == pipe_ctrl_pkg::PH_DEST) begin
			dst_r <= mem_rdata;
		end
	end

	// ==========================================================
	// Execute hand-off at slot end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ex_ir_r <= '0;
			ex_valid_r <= 1'b0;
			ex_pc_r <= pipe_ctrl_pkg::PC_RESET;
			ex_src_r <= '0;
			ex_ret_r <= '0;
		end else if (slot_end) begin
			ex_ir_r <= ir_r;
			ex_valid_r <= ir_valid_r;
			ex_pc_r <= ir_pc_r;
			ex_src_r <= src_r;
			ex_ret_r <= next_addr(ir_pc_r);
		end
	end

	// ==========================================================
	// Result capture after the ALU cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			res_r <= '0;
			res_addr_r <= pipe_ctrl_pkg::PC_RESET;
			res_we_r <= 1'b0;
		end else if (fetch_cyc && !stall) begin
			res_r <= alu_result;
			res_addr_r <= dst_field(ex_ir_r);
			res_we_r <= ex_valid_r && alu_write && ex_ir_r[pipe_ctrl_pkg::WRITE_BIT];
		end else if (run && phase_r == pipe_ctrl_pkg::PH_WRITE) begin
			res_we_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bubble_r <= 1'b0;
		end else if (fetch_cyc && !stall) begin
			bubble_r <= untaken;
		end
	end

	// ==========================================================
	// Memory port: one access per cycle at most
	always_comb begin
		mem_addr = fetch_addr;
		mem_rd = 1'b0;
		mem_we = 1'b0;
		mem_wdata = res_r;
		if (run) begin
			unique case (phase_r)
				pipe_ctrl_pkg::PH_FETCH: begin
					mem_rd = !stall;
				end
				pipe_ctrl_pkg::PH_WRITE: begin
					mem_addr = res_addr_r;
					mem_we = res_we_r;
				end
				pipe_ctrl_pkg::PH_SOURCE: begin
					mem_addr = src_field(ir_r);
					mem_rd = ir_valid_r && !imm_of(ir_r);
				end
				pipe_ctrl_pkg::PH_DEST: begin
					mem_addr = dst_field(ir_r);
					mem_rd = ir_valid_r;
				end
			endcase
		end
	end

	// ==========================================================
	// ALU, hub and status outputs
	assign alu_go = fetch_cyc && ex_valid_r && !stall;
	assign alu_ins = ex_ir_r;
	assign alu_src = ex_src_r;
	// Destination lands at slot end and stands through the ALU cycle
	assign alu_dst = dst_r;
	assign alu_ret_addr = ex_ret_r;
	assign hub_req = fetch_cyc && ex_valid_r && is_hub(ex_ir_r);
	assign retire = alu_go;
	assign bubble = bubble_r;
	assign pc = pc_r;
	assign phase = phase_r;

endmodule // five_stage_instruction_pipeline

// ==== testbench/pipe_chk.sv ====
// Port checker for the five-stage instruction sequencer.
// Assumes one clock domain with an active-low asynchronous reset.
module pipe_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic mem_we,
	input wire logic [pipe_ctrl_pkg::WORD_W-1:0] mem_wdata,
	input wire logic alu_go,
	input wire logic [pipe_ctrl_pkg::WORD_W-1:0] alu_ins,
	input wire logic [pipe_ctrl_pkg::WORD_W-1:0] alu_result,
	input wire logic alu_write,
	input wire logic alu_take,
	input wire logic hub_req,
	input wire logic hub_grant,
	input wire logic retire,
	input wire logic bubble,
	input wire logic [1:0] phase
);
	// ==========================================================
	// Helpers
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic cond_jmp;
	logic wr_res;
	assign cond_jmp = alu_ins[31:26] inside {[6'h38:6'h3B]};
	assign wr_res = alu_write && alu_ins[pipe_ctrl_pkg::WRITE_BIT];

	// ==========================================================
	// Assertions
	a_go_in_alu: assert property (alu_go |-> phase == pipe_ctrl_pkg::PH_FETCH && retire)
		else $error("alu_go outside the ALU cycle");
	a_phase_step: assert property (run && !(hub_req && !hub_grant) |=> phase == $past(phase) + 2'h1)
		else $error("slot phase did not advance");
	a_hub_hold: assert property (hub_req && !hub_grant && run |-> !alu_go ##1 phase == 2'h0)
		else $error("hub stall not held in execute");
	a_hub_grant_go: assert property (hub_req && run |-> phase == 2'h0 && alu_go == hub_grant)
		else $error("hub grant and execute disagree");
	a_write_back: assert property (alu_go && wr_res |=> mem_we && mem_wdata == $past(alu_result))
		else $error("result not written in the next cycle");
	a_no_write: assert property (alu_go && !wr_res |=> !mem_we)
		else $error("write without a result");
	a_write_phase: assert property (mem_we |-> phase == pipe_ctrl_pkg::PH_WRITE)
		else $error("memory write outside the write phase");
	a_slot_four: assert property (alu_go && run && !(cond_jmp && !alu_take) ##1 run [*3] |=> alu_go || hub_req)
		else $error("next instruction not executed four cycles later");
	a_untaken_gap: assert property (alu_go && run && cond_jmp && !alu_take ##1 run [*3] |=> !alu_go)
		else $error("discarded prefetch was executed");
	a_bubble_flag: assert property (alu_go |=> bubble == $past(cond_jmp && !alu_take))
		else $error("bubble flag disagrees with the jump outcome");
	c_untaken: cover property (alu_go && cond_jmp && !alu_take);
	c_hub: cover property (hub_req && hub_grant);
	c_bubble: cover property (bubble);
endmodule // pipe_chk

bind five_stage_instruction_pipeline pipe_chk pipe_chk_i (.clk, .rst_n, .run, .mem_we, .mem_wdata,
	.alu_go, .alu_ins, .alu_result, .alu_write, .alu_take, .hub_req, .hub_grant, .retire, .bubble,
	.phase);

// ==== testbench/side_mem.sv ====
// Far side: local memory with same-cycle read data, and the hub arbiter.
// Assumes the bench loads the memory array while the sequencer is in reset.
module side_mem (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [pipe_ctrl_pkg::ADDR_W-1:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_we,
	input wire logic [pipe_ctrl_pkg::WORD_W-1:0] mem_wdata,
	output logic [pipe_ctrl_pkg::WORD_W-1:0] mem_rdata,
	input wire logic hub_req,
	output logic hub_grant,
	input wire logic [4:0] hub_wait
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [pipe_ctrl_pkg::WORD_W-1:0] mem [512];
	logic [4:0] wait_r;
	// Unread cycles show inverted data
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
	always @(posedge clk) if (mem_we) mem[mem_addr] <= mem_wdata;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) wait_r <= 5'h00;
		else wait_r <= (hub_req && !hub_grant) ? wait_r + 5'h01 : 5'h00;
	end
	assign hub_grant = hub_req && (wait_r >= hub_wait);
endmodule // side_mem

// ==== testbench/testbench.sv ====
// Self-checking bench for the instruction sequencer.
// Assumes side_mem as memory and hub; the ALU adds source and destination.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AW = pipe_ctrl_pkg::ADDR_W;
	localparam int DW = pipe_ctrl_pkg::WORD_W;
	logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, take = 1'b0;
	logic [4:0] hub_wait = 5'h04;
	logic mem_rd, mem_we, alu_go, alu_write, alu_take, hub_req, hub_grant, retire, bubble;
	logic [AW-1:0] mem_addr, alu_ret_addr, pc;
	logic [DW-1:0] mem_wdata, mem_rdata, alu_ins, alu_src, alu_dst, alu_result;
	logic [1:0] phase;
	int fails = 0, n_tests = 0, cyc = 0;
	int t_q[$];
	logic [AW-1:0] a_q[$];
	always #4 clk = ~clk;
	assign alu_result = alu_src + alu_dst;
	assign alu_write = 1'b1;
	assign alu_take = take;
	five_stage_instruction_pipeline five_stage_instruction_pipeline_i (.clk, .rst_n, .run,
		.mem_addr, .mem_rd, .mem_we, .mem_wdata, .mem_rdata, .alu_go, .alu_ins, .alu_src, .alu_dst,
		.alu_ret_addr, .alu_result, .alu_write, .alu_take, .hub_req, .hub_grant, .retire, .bubble,
		.pc, .phase);
	side_mem side_mem_i (.clk, .rst_n, .mem_addr, .mem_rd, .mem_we, .mem_wdata, .mem_rdata,
		.hub_req, .hub_grant, .hub_wait);
	// ==========================================================
	// Retirement log
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (retire === 1'b1) begin
			t_q.push_back(cyc);
			a_q.push_back(alu_ret_addr);
		end
	end
	// ==========================================================
	// Shared tasks
	function automatic logic [DW-1:0] ins(logic [5:0] op, logic w, logic im, int d, int s);
		return {op, 2'h0, w, im, 4'h0, 9'(d), 9'(s)};
	endfunction
	task automatic chk(logic [DW-1:0] seen, logic [DW-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic clear();
		rst_n = 1'b0;
		t_q.delete();
		a_q.delete();
		for (int i = 0; i < 512; i++) side_mem_i.mem[i] = ins(6'h20, 1'b0, 1'b1, 0, 0);
	endtask
	task automatic go(int n);
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		run = 1'b1;
		repeat (n) @(posedge clk);
		#1 run = 1'b0;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_straight();
		clear();
		side_mem_i.mem[0] = ins(6'h20, 1'b1, 1'b1, 10, 5);
		side_mem_i.mem[1] = ins(6'h20, 1'b1, 1'b0, 11, 12);
		side_mem_i.mem[2] = ins(6'h20, 1'b1, 1'b0, 10, 11);
		side_mem_i.mem[10] = 32'h0000_0064;
		side_mem_i.mem[11] = 32'h0000_0007;
		side_mem_i.mem[12] = 32'h0000_0014;
		go(20);
		chk(side_mem_i.mem[11], 32'h0000_001B);
		chk(side_mem_i.mem[10], 32'h0000_0084);
		chk(DW'(pc), 32'h0000_0005);
		for (int i = 0; i < 3; i++) begin
			chk(DW'(a_q[i]), DW'(i + 1));
			chk(DW'(t_q[i + 1] - t_q[i]), 32'h0000_0004);
		end
		$display("t_straight done");
	endtask
	task automatic t_selfmod();
		clear();
		side_mem_i.mem[0] = ins(6'h20, 1'b1, 1'b1, 1, 1);
		side_mem_i.mem[1] = ins(6'h20, 1'b1, 1'b1, 20, 3);
		side_mem_i.mem[20] = 32'h0000_0000;
		go(20);
		chk(side_mem_i.mem[1], ins(6'h20, 1'b1, 1'b1, 20, 4));
		chk(side_mem_i.mem[20], 32'h0000_0003);
		$display("t_selfmod done");
	endtask
	task automatic t_jumps();
		logic [5:0] op [5] = '{6'h17, 6'h38, 6'h39, 6'h3A, 6'h3B};
		logic tk;
		for (int k = 0; k < 5; k++) begin
			clear();
			take = k[0];
			tk = (k == 0) || k[0];
			side_mem_i.mem[0] = ins(op[k], 1'b0, 1'b1, 0, 5);
			go(16);
			chk(DW'(a_q[1]), tk ? 32'h0000_0006 : 32'h0000_0002);
			chk(DW'(t_q[1] - t_q[0]), tk ? 32'h0000_0004 : 32'h0000_0008);
			chk(DW'(pc), tk ? 32'h0000_0008 : 32'h0000_0003);
		end
		$display("t_jumps done");
	endtask
	task automatic t_hub();
		for (int w = 4; w < 20; w += 15) begin
			clear();
			hub_wait = 5'(w);
			side_mem_i.mem[1] = ins(6'h01, 1'b0, 1'b1, 0, 0);
			go(40);
			chk(DW'(t_q[1] - t_q[0]), DW'(w + 4));
		end
		$display("t_hub done");
	endtask
	task automatic end_of_test();
		$display("Checks: %0d, mismatches: %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		t_straight();
		t_selfmod();
		t_jumps();
		t_hub();
		end_of_test();
	end
	initial begin
		#20000;
		fails++;
		end_of_test();
	end
endmodule // testbench
